// [hdl/cbsc_pkg.sv]
// Constants and types for the conditional branch, skip and control decoder
package cbsc_pkg;
	// Instruction kinds presented by the fetch stage
	typedef enum logic [3:0] {
		CBSC_OP_NOP = 4'h0,
		CBSC_OP_BIT_CLEAR = 4'h1,
		CBSC_OP_TEST_CLEAR = 4'h2,
		CBSC_OP_SKIP_CARRY = 4'h3,
		CBSC_OP_SKIP_NO_CARRY = 4'h4,
		CBSC_OP_SKIP_ZERO = 4'h5,
		CBSC_OP_SKIP_NONZERO = 4'h6,
		CBSC_OP_SKIP_HIGHER = 4'h7,
		CBSC_OP_SKIP_NOT_HIGHER = 4'h8,
		CBSC_OP_BANK_SELECT = 4'h9,
		CBSC_OP_INT_UNMASK = 4'ha,
		CBSC_OP_INT_MASK = 4'hb,
		CBSC_OP_HALT = 4'hc,
		CBSC_OP_STOP = 4'hd
	} cbsc_op_t;

	// Bit operand forms
	typedef enum logic [2:0] {
		CBSC_SRC_SADDR = 3'h0,
		CBSC_SRC_SFR = 3'h1,
		CBSC_SRC_ACC = 3'h2,
		CBSC_SRC_PSW = 3'h3,
		CBSC_SRC_PTR = 3'h4,
		CBSC_SRC_SEG_PTR = 3'h5
	} cbsc_src_t;

	// Standby request
	typedef enum logic [1:0] {
		CBSC_SBY_NONE = 2'h0,
		CBSC_SBY_HALT = 2'h1,
		CBSC_SBY_STOP = 2'h2
	} cbsc_sby_t;

	// Issued instruction
	typedef struct packed {
		cbsc_op_t op;
		cbsc_src_t src;
		logic bit_val;
		logic code_flash;
		logic [7:0] disp;
		logic [1:0] bank;
		logic [19:0] pc;
	} cbsc_instr_t;

	// Outcome of one instruction
	typedef struct packed {
		logic [19:0] next_pc;
		logic taken;
		logic skip;
		logic clear_bit;
		logic [3:0] clocks;
		logic [2:0] length;
	} cbsc_result_t;

	localparam logic [2:0] CBSC_LEN_1 = 3'h1;
	localparam logic [2:0] CBSC_LEN_2 = 3'h2;
	localparam logic [2:0] CBSC_LEN_3 = 3'h3;
	localparam logic [2:0] CBSC_LEN_4 = 3'h4;
	localparam logic [3:0] CBSC_CLK_1 = 4'h1;
	localparam logic [3:0] CBSC_CLK_3 = 4'h3;
	localparam logic [3:0] CBSC_CLK_4 = 4'h4;
	localparam logic [3:0] CBSC_CLK_5 = 4'h5;
	localparam logic [3:0] CBSC_CLK_6 = 4'h6;
	localparam logic [3:0] CBSC_CLK_7 = 4'h7;
	localparam logic [3:0] CBSC_CLK_8 = 4'h8;
	localparam logic [1:0] CBSC_BANK_RESET = 2'h0;
	localparam logic CBSC_IE_RESET = 1'b0;
	localparam int CBSC_PC_W = 20;
endpackage

// [hdl/cbsc_decode.sv]
// Combinational outcome: condition, target, length and clock count
`timescale 1ns/1ps
module cbsc_decode (
	input wire cbsc_pkg::cbsc_instr_t i_instr,
	input wire logic i_carry_flag,
	input wire logic i_zero_flag,
	output cbsc_pkg::cbsc_result_t o_result
);
	// Clock count for a bit branch: taken first, untaken second
	function automatic logic [3:0] bit_clocks(input cbsc_pkg::cbsc_src_t src, input logic fl,
		input logic tk);
		logic [3:0] c;
		c = tk ? cbsc_pkg::CBSC_CLK_5 : cbsc_pkg::CBSC_CLK_3;
		if (src == cbsc_pkg::CBSC_SRC_PTR && fl)
			c = tk ? cbsc_pkg::CBSC_CLK_7 : cbsc_pkg::CBSC_CLK_6;
		else if (src == cbsc_pkg::CBSC_SRC_SEG_PTR && fl)
			c = tk ? cbsc_pkg::CBSC_CLK_8 : cbsc_pkg::CBSC_CLK_7;
		else if (src == cbsc_pkg::CBSC_SRC_SEG_PTR)
			c = tk ? cbsc_pkg::CBSC_CLK_6 : cbsc_pkg::CBSC_CLK_4;
		return c;
	endfunction

	// Byte length of a bit branch form
	function automatic logic [2:0] bit_length(input cbsc_pkg::cbsc_src_t src);
		if (src == cbsc_pkg::CBSC_SRC_ACC || src == cbsc_pkg::CBSC_SRC_PTR)
			return cbsc_pkg::CBSC_LEN_3;
		return cbsc_pkg::CBSC_LEN_4;
	endfunction

	logic [19:0] fall_pc;
	logic [19:0] jump_pc;

	// Outcome per instruction kind
	always_comb
	begin
		o_result = '0;
		o_result.length = cbsc_pkg::CBSC_LEN_2;
		o_result.clocks = cbsc_pkg::CBSC_CLK_1;
		fall_pc = '0;
		jump_pc = '0;
		case (i_instr.op)
			cbsc_pkg::CBSC_OP_BIT_CLEAR,
			cbsc_pkg::CBSC_OP_TEST_CLEAR:
			begin
				o_result.length = bit_length(i_instr.src);
				if (i_instr.op == cbsc_pkg::CBSC_OP_BIT_CLEAR)
					o_result.taken = ~i_instr.bit_val;
				else
					o_result.taken = i_instr.bit_val;
				o_result.clear_bit = o_result.taken && i_instr.op == cbsc_pkg::CBSC_OP_TEST_CLEAR;
				o_result.clocks = bit_clocks(i_instr.src, i_instr.code_flash, o_result.taken);
				fall_pc = i_instr.pc + {17'h0_0000, o_result.length};
				jump_pc = fall_pc + {{12{i_instr.disp[7]}}, i_instr.disp};
			end
			cbsc_pkg::CBSC_OP_SKIP_CARRY: o_result.skip = i_carry_flag;
			cbsc_pkg::CBSC_OP_SKIP_NO_CARRY: o_result.skip = ~i_carry_flag;
			cbsc_pkg::CBSC_OP_SKIP_ZERO: o_result.skip = i_zero_flag;
			cbsc_pkg::CBSC_OP_SKIP_NONZERO: o_result.skip = ~i_zero_flag;
			cbsc_pkg::CBSC_OP_SKIP_HIGHER: o_result.skip = ~(i_zero_flag | i_carry_flag);
			cbsc_pkg::CBSC_OP_SKIP_NOT_HIGHER: o_result.skip = i_zero_flag | i_carry_flag;
			cbsc_pkg::CBSC_OP_BANK_SELECT: o_result.clocks = cbsc_pkg::CBSC_CLK_1;
			cbsc_pkg::CBSC_OP_INT_UNMASK,
			cbsc_pkg::CBSC_OP_INT_MASK:
			begin
				o_result.length = cbsc_pkg::CBSC_LEN_3;
				o_result.clocks = cbsc_pkg::CBSC_CLK_4;
			end
			cbsc_pkg::CBSC_OP_HALT,
			cbsc_pkg::CBSC_OP_STOP: o_result.clocks = cbsc_pkg::CBSC_CLK_3;
			cbsc_pkg::CBSC_OP_NOP: o_result.length = cbsc_pkg::CBSC_LEN_1;
			default: o_result.length = cbsc_pkg::CBSC_LEN_1;
		endcase
		if (i_instr.op != cbsc_pkg::CBSC_OP_BIT_CLEAR && i_instr.op != cbsc_pkg::CBSC_OP_TEST_CLEAR)
			fall_pc = i_instr.pc + {17'h0_0000, o_result.length};
		o_result.next_pc = o_result.taken ? jump_pc : fall_pc;
	end
endmodule

// [hdl/cbsc_ctrl.sv]
// Executes branch, skip, bank, interrupt and standby instructions
`timescale 1ns/1ps
module cbsc_ctrl (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_valid,
	input wire cbsc_pkg::cbsc_instr_t i_instr,
	input wire logic i_carry_flag,
	input wire logic i_zero_flag,
	input wire logic i_wake,
	output logic o_ready,
	output logic o_done,
	output logic [19:0] o_next_pc,
	output logic o_skip_next,
	output logic o_clear_bit,
	output logic [1:0] o_register_bank_select,
	output logic o_interrupt_enable_flag,
	output cbsc_pkg::cbsc_sby_t o_standby
);
	// Sequencer states, Gray along idle, busy, sleep
	typedef enum logic [1:0] {
		CBSC_ST_IDLE = 2'b00,
		CBSC_ST_BUSY = 2'b01,
		CBSC_ST_SLEEP = 2'b11
	} cbsc_state_t;

	// Decoded outcome, then registered state and its next values
	cbsc_pkg::cbsc_result_t res;
	cbsc_state_t state;
	cbsc_state_t next_state;
	logic [3:0] count;
	logic [3:0] next_count;
	logic ready;
	logic next_ready;
	logic done;
	logic next_done;
	logic [19:0] pc;
	logic [19:0] next_pc;
	logic skip;
	logic next_skip;
	logic clr;
	logic next_clr;
	logic [1:0] bank;
	logic [1:0] next_bank;
	logic ie;
	logic next_ie;
	cbsc_pkg::cbsc_sby_t sby;
	cbsc_pkg::cbsc_sby_t next_sby;
	cbsc_pkg::cbsc_sby_t held_sby;
	cbsc_pkg::cbsc_sby_t next_held_sby;
	// Wake filter state
	logic [2:0] wake_sync;
	logic [2:0] next_wake_sync;
	logic wake;
	logic next_wake;

	// Outcome of the presented instruction
	cbsc_decode u_decode (
		.i_instr(i_instr),
		.i_carry_flag(i_carry_flag),
		.i_zero_flag(i_zero_flag),
		.o_result(res)
	);

	// Wake filter: wake may come from outside this clock, so three stages
	// A change counts only once stages two and three agree
	always_comb
	begin
		next_wake_sync = {wake_sync[1:0], i_wake}; // Stage one only feeds stage two
		next_wake = wake;
		if (wake_sync[1] == wake_sync[2])
			next_wake = wake_sync[1];
	end

	// Wake filter registers
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			wake_sync <= 3'h0;
			wake <= 1'b0;
		end
		else
		begin
			wake_sync <= next_wake_sync;
			wake <= next_wake;
		end
	end

	// Sequencer: accept, count clocks, retire, enter standby
	always_comb
	begin
		next_state = state;
		next_count = count;
		next_ready = ready;
		next_done = 1'b0;
		next_pc = pc;
		next_skip = skip;
		next_clr = clr;
		next_bank = bank;
		next_ie = ie;
		next_sby = sby;
		next_held_sby = held_sby;
		case (state)
			CBSC_ST_IDLE:
			begin
				if (i_valid)
				begin
					next_pc = res.next_pc;
					next_skip = res.skip;
					next_clr = res.clear_bit;
					next_held_sby = cbsc_pkg::CBSC_SBY_NONE;
					case (i_instr.op)
						cbsc_pkg::CBSC_OP_BANK_SELECT: next_bank = i_instr.bank;
						cbsc_pkg::CBSC_OP_INT_UNMASK: next_ie = 1'b1;
						cbsc_pkg::CBSC_OP_INT_MASK: next_ie = 1'b0;
						cbsc_pkg::CBSC_OP_HALT: next_held_sby = cbsc_pkg::CBSC_SBY_HALT;
						cbsc_pkg::CBSC_OP_STOP: next_held_sby = cbsc_pkg::CBSC_SBY_STOP;
						default: next_held_sby = cbsc_pkg::CBSC_SBY_NONE;
					endcase
					if (res.clocks == cbsc_pkg::CBSC_CLK_1)
						next_done = 1'b1;
					else
					begin
						next_ready = 1'b0;
						next_count = res.clocks - cbsc_pkg::CBSC_CLK_1;
						next_state = CBSC_ST_BUSY;
					end
				end
			end
			CBSC_ST_BUSY:
			begin
				next_count = count - cbsc_pkg::CBSC_CLK_1;
				if (count == cbsc_pkg::CBSC_CLK_1)
				begin
					next_done = 1'b1;
					if (held_sby != cbsc_pkg::CBSC_SBY_NONE)
					begin
						next_sby = held_sby;
						next_state = CBSC_ST_SLEEP;
					end
					else
					begin
						next_ready = 1'b1;
						next_state = CBSC_ST_IDLE;
					end
				end
			end
			CBSC_ST_SLEEP:
			begin
				// Stays asleep until the filtered wake is seen
				if (wake)
				begin
					next_sby = cbsc_pkg::CBSC_SBY_NONE;
					next_ready = 1'b1;
					next_state = CBSC_ST_IDLE;
				end
			end
			default:
			begin
				next_state = CBSC_ST_IDLE;
				next_ready = 1'b1;
			end
		endcase
	end

	// State registers
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			state <= CBSC_ST_IDLE;
			count <= 4'h0;
			ready <= 1'b1;
			done <= 1'b0;
			pc <= 20'h0_0000;
			skip <= 1'b0;
			clr <= 1'b0;
			bank <= cbsc_pkg::CBSC_BANK_RESET;
			ie <= cbsc_pkg::CBSC_IE_RESET;
			sby <= cbsc_pkg::CBSC_SBY_NONE;
			held_sby <= cbsc_pkg::CBSC_SBY_NONE;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
			ready <= next_ready;
			done <= next_done;
			pc <= next_pc;
			skip <= next_skip;
			clr <= next_clr;
			bank <= next_bank;
			ie <= next_ie;
			sby <= next_sby;
			held_sby <= next_held_sby;
		end
	end

	// Outputs straight from registers
	assign o_ready = ready;
	assign o_done = done;
	assign o_next_pc = pc;
	assign o_skip_next = skip;
	assign o_clear_bit = clr;
	assign o_register_bank_select = bank;
	assign o_interrupt_enable_flag = ie;
	assign o_standby = sby;
endmodule

// [bench/cbsc_checker.sv]
// Port checks for the branch, skip and control decoder
`timescale 1ns/1ps
module cbsc_checker (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_valid,
	input wire cbsc_pkg::cbsc_instr_t i_instr,
	input wire logic i_carry_flag,
	input wire logic o_ready,
	input wire logic o_done,
	input wire logic [19:0] o_next_pc,
	input wire logic o_skip_next,
	input wire logic o_clear_bit,
	input wire logic [1:0] o_register_bank_select,
	input wire logic o_interrupt_enable_flag,
	input wire cbsc_pkg::cbsc_sby_t o_standby
);
	// Accepted request, its kind and a 4-byte target
	wire acc = i_valid && o_ready;
	wire [3:0] op = i_instr.op;
	wire bc = acc && op == 4'h1;
	wire sfr = bc && i_instr.src == cbsc_pkg::CBSC_SRC_SFR;
	wire [19:0] tgt = i_instr.pc + 20'h0_0004 + {{12{i_instr.disp[7]}}, i_instr.disp};
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	sfr_taken_a: assert property (sfr && !i_instr.bit_val |=> !o_done[*4] ##1 o_done)
		else $error("taken bit branch count wrong");
	sfr_untaken_a: assert property (sfr && i_instr.bit_val |=> !o_done[*2] ##1 o_done)
		else $error("untaken bit branch count wrong");
	branch_target_a: assert property (bc && i_instr.src == 3'h0 && !i_instr.bit_val
		|=> o_next_pc == $past(tgt)) else $error("branch target wrong");
	clear_bit_a: assert property (acc && op == 4'h2 |=> o_clear_bit == $past(i_instr.bit_val))
		else $error("clear request wrong");
	skip_carry_a: assert property (acc && op == 4'h3 |=> o_done && o_skip_next == $past(i_carry_flag))
		else $error("carry skip wrong");
	bank_load_a: assert property (acc && op == 4'h9
		|=> o_register_bank_select == $past(i_instr.bank)) else $error("bank not loaded");
	ie_set_a: assert property (acc && op == 4'ha |=> o_interrupt_enable_flag ##3 o_done)
		else $error("unmask wrong");
	ie_clear_a: assert property (acc && op == 4'hb |=> !o_interrupt_enable_flag && !o_ready)
		else $error("mask wrong");
	halt_entry_a: assert property (acc && op == 4'hc
		|=> !o_ready[*2] ##1 o_standby == cbsc_pkg::CBSC_SBY_HALT) else $error("halt entry wrong");
	cover property (sfr && !i_instr.bit_val);
	cover property (acc && op == 4'h2 && i_instr.bit_val);
	cover property (acc && op == 4'hd);
endmodule
bind cbsc_ctrl cbsc_checker i_cbsc_checker (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(i_valid),
	.i_instr(i_instr), .i_carry_flag(i_carry_flag), .o_ready(o_ready), .o_done(o_done),
	.o_next_pc(o_next_pc), .o_skip_next(o_skip_next), .o_clear_bit(o_clear_bit),
	.o_register_bank_select(o_register_bank_select),
	.o_interrupt_enable_flag(o_interrupt_enable_flag), .o_standby(o_standby));

// [bench/cbsc_fetch_model.sv]
// Fetch side model: presents one instruction until taken
`timescale 1ns/1ps
module cbsc_fetch_model (
	input wire logic i_clk,
	input wire logic i_go,
	input wire cbsc_pkg::cbsc_instr_t i_req,
	input wire logic i_ready,
	output logic o_valid,
	output cbsc_pkg::cbsc_instr_t o_instr
);
	// Hold until accepted, then scramble the released bus
	initial
	begin
		o_valid = 1'b0;
		o_instr = '0;
		forever
		begin
			@(posedge i_clk);
			if (o_valid && i_ready)
			begin
				#1 o_valid = 1'b0;
				o_instr = ~o_instr;
			end
			else if (i_go && !o_valid)
			begin
				#1 o_valid = 1'b1;
				o_instr = i_req;
			end
		end
	end
endmodule

// [bench/cbsc_ctrl_tb_top.sv]
// Self-checking bench for the branch, skip and control decoder
`timescale 1ns/1ps
`define CHK(a, b) chk_v(32'(a), 32'(b))
module cbsc_ctrl_tb_top;
	logic i_clk = 0, i_nrst = 0, go = 0, cy = 0, zf = 0, wk = 0, vld, rdy, dn, sk, clr, ie;
	cbsc_pkg::cbsc_instr_t rq = '0, ins;
	logic [19:0] npc;
	logic [1:0] bk;
	cbsc_pkg::cbsc_sby_t sby;
	int err_total = 0, n_compared = 0, cyc = 0, n;
	localparam int wake_lat = 5; // Three wake sync stages and the filtered wake register, then one edge to leave standby
	cbsc_fetch_model i_cbsc_fetch_model (.i_clk(i_clk), .i_go(go), .i_req(rq), .i_ready(rdy),
		.o_valid(vld), .o_instr(ins));
	cbsc_ctrl i_cbsc_ctrl (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(vld), .i_instr(ins),
		.i_carry_flag(cy), .i_zero_flag(zf), .i_wake(wk), .o_ready(rdy), .o_done(dn),
		.o_next_pc(npc), .o_skip_next(sk), .o_clear_bit(clr), .o_register_bank_select(bk),
		.o_interrupt_enable_flag(ie), .o_standby(sby));
	initial forever #5 i_clk = ~i_clk;
	// Hang guard
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_total++;
			test_done;
		end
	end
	task chk_v(input logic [31:0] a, e);
		n_compared++;
		if (a !== e)
		begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, a, e);
		end
	endtask
	task test_done;
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Issue one instruction at pc 0x01000, count clocks to retire
	task run(input cbsc_pkg::cbsc_op_t o, input int s, b, f, input logic [7:0] d);
		rq = '{o, cbsc_pkg::cbsc_src_t'(s), b[0], f[0], d, d[1:0], 20'h0_1000};
		go = 1;
		@(posedge i_clk);
		#1 go = 0;
		@(negedge i_clk);
		while (!(vld && rdy)) @(negedge i_clk);
		n = 1; // The accept edge is the first clock
		@(posedge i_clk);
		#1;
		while (!dn && n < 9)
		begin
			@(posedge i_clk);
			#1 n++;
		end
	endtask
	task t_bitclr;
		for (int s = 0; s < 6; s++) for (int b = 0; b < 2; b++) for (int f = 0; f < 2; f++)
		begin
			run(cbsc_pkg::CBSC_OP_BIT_CLEAR, s, b, f, 8'hf0);
			`CHK(n, (s == 5 ? (f ? 7 : 4) : (s == 4 && f) ? 6 : 3) + (b ? 0 : (f && s > 3) ? 1 : 2));
			`CHK(npc, 20'h0_1000 + ((s == 2 || s == 4) ? 3 : 4) - (b ? 0 : 16));
			`CHK(clr, 0);
		end
	endtask
	task t_tclr;
		for (int s = 0; s < 6; s++) for (int b = 0; b < 2; b++)
		begin
			run(cbsc_pkg::CBSC_OP_TEST_CLEAR, s, b, 0, 8'h10);
			`CHK(n, (s == 5 ? 4 : 3) + (b ? 2 : 0));
			`CHK(npc, 20'h0_1000 + ((s == 2 || s == 4) ? 3 : 4) + (b ? 16 : 0));
			`CHK(clr, b);
		end
	endtask
	task t_skip;
		for (int o = 3; o < 9; o++) for (int k = 0; k < 4; k++)
		begin
			{cy, zf} = k[1:0];
			run(cbsc_pkg::cbsc_op_t'(o), 0, 0, 0, 8'h00);
			`CHK(n, 1);
			`CHK(npc, 20'h0_1002);
			`CHK(sk, o == 3 ? cy : o == 4 ? !cy : o == 5 ? zf : o == 6 ? !zf : (o == 7) ^ (zf | cy));
		end
	endtask
	task t_ctrl;
		`CHK({bk, ie, sby, rdy}, 6'h01);
		for (int k = 3; k >= 0; k--)
		begin
			run(cbsc_pkg::CBSC_OP_BANK_SELECT, 0, 0, 0, 8'(k));
			`CHK({n, bk}, {32'h1, 2'(k)});
		end
		run(cbsc_pkg::CBSC_OP_INT_UNMASK, 0, 0, 0, 8'h00);
		`CHK({n, ie, npc}, {32'h4, 1'b1, 20'h0_1003});
		run(cbsc_pkg::CBSC_OP_INT_MASK, 0, 0, 0, 8'h00);
		`CHK({n, ie, npc}, {32'h4, 1'b0, 20'h0_1003});
		run(cbsc_pkg::CBSC_OP_NOP, 0, 0, 0, 8'h00);
		`CHK({n, npc, bk}, {32'h1, 20'h0_1001, 2'h0});
	endtask
	task t_sby;
		for (int k = 0; k < 2; k++)
		begin
			run(k ? cbsc_pkg::CBSC_OP_STOP : cbsc_pkg::CBSC_OP_HALT, 0, 0, 0, 8'h00);
			`CHK({n, sby, rdy}, {32'h3, 2'(k + 1), 1'b0});
			repeat (3) @(posedge i_clk);
			#1 wk = 1;
			n = 0;
			while (!rdy && n < 8)
			begin
				@(posedge i_clk);
				#1 n++;
			end
			wk = 0;
			`CHK({rdy, sby}, 3'h4);
			`CHK(n, wake_lat);
			// Let the filter see wake low before the next standby entry
			repeat (4) @(posedge i_clk);
			#1;
		end
	endtask
	// Reset, then the scenarios
	initial
	begin
		repeat (4) @(posedge i_clk);
		#1 i_nrst = 1;
		t_ctrl;
		t_bitclr;
		t_tclr;
		t_skip;
		t_sby;
		test_done;
	end
endmodule
